// ### rtl/adc_pf_pkg.sv
package adc_pf_pkg;
	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_MODE0 = 6'h00;
	localparam logic [5:0] ADDR_MODE2 = 6'h04;
	localparam logic [5:0] ADDR_SELECT = 6'h08;
	localparam logic [5:0] ADDR_PF_MODE = 6'h0c;
	localparam logic [5:0] ADDR_PF_THRESHOLD = 6'h10;
	localparam logic [5:0] ADDR_FLAG = 6'h14;
	localparam logic [5:0] ADDR_RESULT_BASE = 6'h20;
	localparam int ADDR_W = 7;
	// ------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------
	localparam int MODE_CE_BIT = 7;
	localparam int MODE_EF_BIT = 6;
	localparam int MODE_MD_LSB = 4;
	localparam int PF_ENABLE_BIT = 7;
	localparam int PF_DIR_BIT = 6;
	localparam int RES_W = 10;
	localparam int HIGH_W = 8;
	localparam int CH_W = 4;
	localparam int NUM_CH = 16;
	// ------------------------------------------------------------
	// operation modes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_CONT_SELECT = 2'b00,
		MODE_CONT_SCAN = 2'b01,
		MODE_ONE_SELECT = 2'b10,
		MODE_ONE_SCAN = 2'b11
	} op_mode_e;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int CONV_TIME_NS = 1000;
	localparam int CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : adc_pf_pkg

// ### rtl/result_if.sv
`timescale 1ns/1ns
interface result_if;
	logic wr_en;
	logic [3:0] wr_ch;
	logic [9:0] wr_data;
	logic [3:0] rd_ch;
	logic [9:0] rd_data;
	logic [9:0] ch0_data;
	modport ctrl (output wr_en, wr_ch, wr_data, rd_ch, input rd_data, ch0_data);
	modport mem (input wr_en, wr_ch, wr_data, rd_ch, output rd_data, ch0_data);
endinterface : result_if

// ### rtl/result_store.sv
`timescale 1ns/1ns
module result_store (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// port to the controller
	result_if.mem bus
);
	logic [adc_pf_pkg::RES_W-1:0] mem_reg [adc_pf_pkg::NUM_CH];
	logic [adc_pf_pkg::RES_W-1:0] rd_reg;

	// one result word per channel, written at each conversion end
	genvar g;
	generate
		for (g = 0; g < adc_pf_pkg::NUM_CH; g++) begin : g_ch
			always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
				if (!i_rst_n) begin
					mem_reg[g] <= '0;
				end else if (bus.wr_en && bus.wr_ch == g[3:0]) begin
					mem_reg[g] <= bus.wr_data;
				end
			end
		end
	endgenerate

	// registered read port
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_reg <= '0;
		end else begin
			rd_reg <= mem_reg[bus.rd_ch];
		end
	end

	assign bus.rd_data = rd_reg;
	assign bus.ch0_data = mem_reg[0];
endmodule : result_store

// ### rtl/sar_core.sv
`timescale 1ns/1ns
module sar_core (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// control
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [9:0] i_sample,
	// outputs
	output logic o_done,
	output logic [9:0] o_result
);
	logic [7:0] cnt_reg;
	logic busy_reg;

	// fixed-length conversion; sample latched at the end
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			o_done <= 1'b0;
			o_result <= '0;
		end else begin
			o_done <= 1'b0;
			if (i_abort) begin
				busy_reg <= 1'b0;
			end else if (i_start) begin
				busy_reg <= 1'b1;
				cnt_reg <= 8'(adc_pf_pkg::CONV_CYCLES - 1);
			end else if (busy_reg) begin
				if (cnt_reg == 8'h00) begin
					busy_reg <= 1'b0;
					o_done <= 1'b1;
					o_result <= i_sample;
				end else begin
					cnt_reg <= cnt_reg - 8'h01;
				end
			end
		end
	end
endmodule : sar_core

// ### rtl/adc_power_fail_compare.sv
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
// Overview of operation
// - compare off: interrupt on every conversion end in select modes, at the end of each sweep in scan modes
// - direction 0: interrupt if high byte >= threshold
// - direction 1: interrupt if high byte < threshold
// - result always stored, only interrupt and end flag suppressed
// - continuous select repeats until enable cleared
// - scan modes compare channel 0 high byte only
// - continuous scan sweeps 0..select, then restarts
// - one-shot modes convert once then stop
// - clearing enable stops converter, powers down
// - select rewrite does not clear end flag
// - 10-bit results for sixteen channels
// - control register write restarts ongoing conversion
// - active status bit set when conversion starts
module adc_power_fail_compare (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// axi4-lite write address and data
	input wire logic [6:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	// axi4-lite write response
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// axi4-lite read
	input wire logic [6:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// analog front end: digitised sample of the selected channel
	input wire logic [9:0] i_analog_sample,
	output logic [3:0] o_analog_channel,
	output logic o_analog_power,
	// conversion end interrupt
	output logic o_conv_end_irq
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_CONV = 2'b10
	} conv_state_e;

	logic rst_meta_reg;
	logic rst_sync_n;
	conv_state_e state_reg;
	logic [7:0] mode0_reg;
	logic [7:0] mode2_reg;
	logic [3:0] channel_select_reg;
	logic [7:0] pf_mode_reg;
	logic [7:0] pf_threshold_reg;
	logic conv_end_flag;
	logic [3:0] cur_ch_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [6:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic rd_pend_reg;
	logic [6:0] araddr_reg;
	logic wr_fire;
	logic ctrl_write;
	logic launch_reg;
	logic [6:0] rd_addr;
	logic [4:0] res_index;
	logic conv_enable;
	logic conv_active_flag;
	adc_pf_pkg::op_mode_e mode;
	logic core_start;
	logic core_abort;
	logic core_done;
	logic [9:0] core_result;
	logic [7:0] compare_high;
	logic pf_compare_enable;
	logic pf_compare_direction;
	logic cmp_hit;
	logic last_ch;
	logic scan_mode;
	logic raise_irq;
	result_if res();

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	// two-stage synchroniser of the reset release
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_n <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// axi4-lite slave
	// ------------------------------------------------------------
	// hold address and data until both are present
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			o_bvalid <= 1'b0;
			o_bresp <= adc_pf_pkg::RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= i_wdata;
				wstrb_reg <= i_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (!awaddr_reg[6] && awaddr_reg[5:0] <= adc_pf_pkg::ADDR_FLAG)
					? adc_pf_pkg::RESP_OKAY : adc_pf_pkg::RESP_SLVERR;
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	assign wr_fire = aw_held_reg && w_held_reg && !o_bvalid;
	assign ctrl_write = wr_fire && wstrb_reg[0] && (awaddr_reg[5:0] != adc_pf_pkg::ADDR_FLAG)
		&& awaddr_reg[6:5] == 2'b00 && awaddr_reg[4:0] <= 5'h10;

	// ready flags are registered so outputs come from flip-flops
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_arready <= 1'b0;
		end else begin
			o_awready <= !aw_held_reg && !(i_awvalid && o_awready) && !wr_fire;
			o_wready <= !w_held_reg && !(i_wvalid && o_wready) && !wr_fire;
			o_arready <= !rd_pend_reg && !(i_arvalid && o_arready) && !o_rvalid;
		end
	end

	// control registers; the low byte lane carries every field
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mode0_reg <= '0;
			mode2_reg <= '0;
			channel_select_reg <= '0;
			pf_mode_reg <= '0;
			pf_threshold_reg <= '0;
		end else if (wr_fire && wstrb_reg[0]) begin
			unique case (awaddr_reg[5:0])
				adc_pf_pkg::ADDR_MODE0: mode0_reg <= {wdata_reg[7], 1'b0, wdata_reg[5:0]};
				adc_pf_pkg::ADDR_MODE2: mode2_reg <= wdata_reg[7:0];
				adc_pf_pkg::ADDR_SELECT: channel_select_reg <= wdata_reg[3:0];
				adc_pf_pkg::ADDR_PF_MODE: pf_mode_reg <= {wdata_reg[7:6], 6'h00};
				adc_pf_pkg::ADDR_PF_THRESHOLD: pf_threshold_reg <= wdata_reg[7:0];
				default: ;
			endcase
		end
	end

	// read path: result words go through the store read register
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_pend_reg <= 1'b0;
			araddr_reg <= '0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= adc_pf_pkg::RESP_OKAY;
		end else begin
			if (i_arvalid && o_arready) begin
				rd_pend_reg <= 1'b1;
				araddr_reg <= i_araddr;
			end else if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				o_rvalid <= 1'b1;
				o_rresp <= adc_pf_pkg::RESP_OKAY;
				if (!res_index[4]) begin
					o_rdata <= {22'h000000, res.rd_data};
				end else if (araddr_reg[6:5] != 2'b00) begin
					o_rresp <= adc_pf_pkg::RESP_SLVERR;
					o_rdata <= '0;
				end else begin
					unique case (araddr_reg[5:0])
						adc_pf_pkg::ADDR_MODE0: o_rdata <= {24'h000000, conv_enable,
							conv_active_flag, mode0_reg[5:0]};
						adc_pf_pkg::ADDR_MODE2: o_rdata <= {24'h000000, mode2_reg};
						adc_pf_pkg::ADDR_SELECT: o_rdata <= {28'h0000000, channel_select_reg};
						adc_pf_pkg::ADDR_PF_MODE: o_rdata <= {24'h000000, pf_mode_reg};
						adc_pf_pkg::ADDR_PF_THRESHOLD: o_rdata <= {24'h000000, pf_threshold_reg};
						adc_pf_pkg::ADDR_FLAG: o_rdata <= {31'h00000000, conv_end_flag};
						default: begin
							o_rdata <= '0;
							o_rresp <= adc_pf_pkg::RESP_SLVERR;
						end
					endcase
				end
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	// word index from the bus on the accept edge, so the store register is ready in time
	assign rd_addr = (i_arvalid && o_arready) ? i_araddr : araddr_reg;
	assign res_index = rd_addr[6:2] - 5'(adc_pf_pkg::ADDR_RESULT_BASE >> 2);
	assign res.rd_ch = res_index[3:0];

	// ------------------------------------------------------------
	// conversion sequencing
	// ------------------------------------------------------------
	assign conv_enable = mode0_reg[adc_pf_pkg::MODE_CE_BIT];
	assign mode = adc_pf_pkg::op_mode_e'(mode0_reg[adc_pf_pkg::MODE_MD_LSB +: 2]);
	assign scan_mode = (mode == adc_pf_pkg::MODE_CONT_SCAN) || (mode == adc_pf_pkg::MODE_ONE_SCAN);
	assign conv_active_flag = (state_reg != ST_IDLE);
	assign last_ch = !scan_mode || (cur_ch_reg == channel_select_reg);
	// control writes act a cycle late, once the new field values stand
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			launch_reg <= 1'b0;
		end else begin
			launch_reg <= ctrl_write;
		end
	end

	// idle, launch, convert; writes to control registers relaunch
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg <= ST_IDLE;
			cur_ch_reg <= '0;
		end else if (!conv_enable) begin
			state_reg <= ST_IDLE;
		end else if (launch_reg) begin
			state_reg <= ST_START;
			cur_ch_reg <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: state_reg <= ST_IDLE;
				ST_START: state_reg <= ST_CONV;
				ST_CONV: begin
					if (core_done) begin
						if (!last_ch) begin
							cur_ch_reg <= cur_ch_reg + 4'h1;
							state_reg <= ST_START;
						end else if (mode == adc_pf_pkg::MODE_CONT_SELECT
							|| mode == adc_pf_pkg::MODE_CONT_SCAN) begin
							cur_ch_reg <= '0;
							state_reg <= ST_START;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign core_start = (state_reg == ST_START);
	assign core_abort = !conv_enable || launch_reg;

	// select pin follows the scan counter or the select register; converter power follows the enable bit
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			o_analog_channel <= '0;
			o_analog_power <= 1'b0;
		end else begin
			o_analog_channel <= scan_mode ? cur_ch_reg : channel_select_reg;
			o_analog_power <= conv_enable;
		end
	end

	sar_core u_core (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_sync_n),
		.i_start(core_start),
		.i_abort(core_abort),
		.i_sample(i_analog_sample),
		.o_done(core_done),
		.o_result(core_result)
	);

	// ------------------------------------------------------------
	// result storage and power-fail compare
	// ------------------------------------------------------------
	assign res.wr_en = core_done && conv_active_flag && conv_enable && !launch_reg;
	assign res.wr_ch = o_analog_channel;
	assign res.wr_data = core_result;

	result_store u_store (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(rst_sync_n),
		.bus(res.mem)
	);

	assign pf_compare_enable = pf_mode_reg[adc_pf_pkg::PF_ENABLE_BIT];
	assign pf_compare_direction = pf_mode_reg[adc_pf_pkg::PF_DIR_BIT];
	// channel 0 result in scan modes, fresh result otherwise
	assign compare_high = (scan_mode && o_analog_channel != 4'h0)
		? res.ch0_data[9:2] : core_result[9:2];
	assign cmp_hit = pf_compare_direction ? (compare_high < pf_threshold_reg)
		: (compare_high >= pf_threshold_reg);
	assign raise_irq = res.wr_en && last_ch && (!pf_compare_enable || cmp_hit);

	// end flag: set wins over software clear; select writes leave it
	always_ff @(posedge i_clk_sys or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			conv_end_flag <= 1'b0;
			o_conv_end_irq <= 1'b0;
		end else begin
			o_conv_end_irq <= raise_irq;
			if (raise_irq) begin
				conv_end_flag <= 1'b1;
			end else if (wr_fire && wstrb_reg[0] && awaddr_reg[5:0] == adc_pf_pkg::ADDR_FLAG
				&& !awaddr_reg[6] && wdata_reg[0]) begin
				conv_end_flag <= 1'b0;
			end
		end
	end
endmodule : adc_power_fail_compare

// ### test/analog_source_model.sv
`timescale 1ns/1ns
// ----
// analog front end: channel level, noise while powered down
// ----
module analog_source_model (
	// clock
	input wire logic i_clk_sys,
	// converter side
	input wire logic i_power,
	input wire logic [3:0] i_channel,
	output logic [9:0] o_sample
);
	logic [9:0] junk_reg = 10'h2aa;
	// pattern flips each cycle; its 10'h155 phase equals the channel 5 level
	always @(posedge i_clk_sys) begin
		junk_reg <= ~junk_reg;
	end
	// level: channel number in the top bits
	assign o_sample = i_power ? {i_channel, 6'h15} : junk_reg;
endmodule : analog_source_model

// ### test/adc_pf_properties.sv
`timescale 1ns/1ns
// ----
// bus and interrupt timing checks
// ----
module adc_pf_checker (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// register bus
	input wire logic [6:0] i_awaddr,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [6:0] i_araddr,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp,
	input wire logic o_rvalid,
	input wire logic i_rready,
	// converter
	input wire logic [9:0] i_analog_sample,
	input wire logic [3:0] o_analog_channel,
	input wire logic o_analog_power,
	input wire logic o_conv_end_irq
);
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	// interrupt timing
	a_irq_spacing: assert property (o_conv_end_irq |=> !o_conv_end_irq [*8])
		else $error("irq pulses too close");
	a_off_no_irq: assert property (!o_analog_power [*3] |-> !o_conv_end_irq)
		else $error("irq while powered down");
	a_start_quiet: assert property ($rose(o_analog_power) |-> !o_conv_end_irq [*8])
		else $error("irq before a conversion could end");
	// bus timing
	a_rd_latency: assert property (i_arvalid && o_arready |-> ##2 o_rvalid)
		else $error("read answer late");
	a_wr_latency: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
		else $error("write answer late");
	a_rd_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_wr_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_unmapped_err: assert property (i_arvalid && o_arready && i_araddr == 7'h18
		|-> ##2 o_rresp == adc_pf_pkg::RESP_SLVERR && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	// main scenarios
	c_irq: cover property (o_conv_end_irq);
	c_power: cover property ($rose(o_analog_power));
	c_slverr: cover property (o_rvalid && o_rresp == adc_pf_pkg::RESP_SLVERR);
endmodule : adc_pf_checker

bind adc_power_fail_compare adc_pf_checker adc_pf_checker_inst (.*);

// ### test/testbench.sv
`timescale 1ns/1ns
module testbench;
	// ----
	// design signals
	// ----
	logic i_clk_sys = 1'b0;
	logic i_rst_n = 1'b0;
	logic [6:0] i_awaddr = 7'h00;
	logic i_awvalid = 1'b0;
	logic o_awready;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic i_wvalid = 1'b0;
	logic o_wready;
	logic [1:0] o_bresp;
	logic o_bvalid;
	logic i_bready = 1'b0;
	logic [6:0] i_araddr = 7'h00;
	logic i_arvalid = 1'b0;
	logic o_arready;
	logic [31:0] o_rdata;
	logic [1:0] o_rresp;
	logic o_rvalid;
	logic i_rready = 1'b0;
	logic [9:0] i_analog_sample;
	logic [3:0] o_analog_channel;
	logic o_analog_power;
	logic o_conv_end_irq;
	// bench state
	int num_errors = 0;
	int check_count = 0;
	int irq_cnt = 0;
	int n;
	logic [31:0] rd_data;
	logic [1:0] rd_resp;
	logic [7:0] pf_tab [5] = '{8'h00, 8'h80, 8'h80, 8'hc0, 8'hc0};
	logic [7:0] thr_tab [5] = '{8'hff, 8'h35, 8'h36, 8'h35, 8'h36};
	logic exp_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
	// clock and interrupt pulse counter
	always #5 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) begin
		if (o_conv_end_irq === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	// design and analog source
	adc_power_fail_compare adc_power_fail_compare_inst (.*);
	analog_source_model analog_source_model_inst (.i_clk_sys(i_clk_sys),
		.i_power(o_analog_power), .i_channel(o_analog_channel), .o_sample(i_analog_sample));
	// ----
	// bus tasks
	// ----
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bit ka;
		bit kw;
		ka = 1'b0;
		kw = 1'b0;
		@(posedge i_clk_sys);
		i_awaddr <= {1'b0, a};
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		while (!(ka && kw)) begin
			@(posedge i_clk_sys);
			if (!ka && o_awready === 1'b1) begin
				ka = 1'b1;
				i_awvalid <= 1'b0;
			end
			if (!kw && o_wready === 1'b1) begin
				kw = 1'b1;
				i_wvalid <= 1'b0;
			end
		end
		while (o_bvalid !== 1'b1) @(posedge i_clk_sys);
		i_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge i_clk_sys);
		i_araddr <= {1'b0, a};
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do @(posedge i_clk_sys); while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
		do @(posedge i_clk_sys); while (o_rvalid !== 1'b1);
		rd_data = o_rdata;
		rd_resp = o_rresp;
		i_rready <= 1'b0;
	endtask : rd
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : final_report
	// ----
	// tests
	// ----
	initial begin
		repeat (3) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
		// one-shot select of channel 3 under each compare setting
		wr(adc_pf_pkg::ADDR_SELECT, 32'h3);
		for (int i = 0; i < 5; i++) begin
			wr(adc_pf_pkg::ADDR_MODE0, 32'h20);
			wr(adc_pf_pkg::ADDR_PF_MODE, {24'h0, pf_tab[i]});
			wr(adc_pf_pkg::ADDR_PF_THRESHOLD, {24'h0, thr_tab[i]});
			wr(adc_pf_pkg::ADDR_FLAG, 32'h1);
			n = irq_cnt;
			wr(adc_pf_pkg::ADDR_MODE0, 32'ha0);
			rd(adc_pf_pkg::ADDR_MODE0);
			check("active", {31'h0, rd_data[6]}, 32'h1);
			repeat (250) @(posedge i_clk_sys);
			check("irq", 32'(irq_cnt - n), {31'h0, exp_tab[i]});
			rd(adc_pf_pkg::ADDR_FLAG);
			check("flag", rd_data, {31'h0, exp_tab[i]});
			rd(adc_pf_pkg::ADDR_RESULT_BASE + 6'h0c);
			check("result", rd_data, 32'h0d5);
		end
		$display("done: one-shot compare");
		// continuous scan 0..3 with channel 0 below threshold
		wr(adc_pf_pkg::ADDR_MODE0, 32'h10);
		wr(adc_pf_pkg::ADDR_PF_MODE, 32'h80);
		wr(adc_pf_pkg::ADDR_PF_THRESHOLD, 32'h06);
		wr(adc_pf_pkg::ADDR_FLAG, 32'h1);
		n = irq_cnt;
		wr(adc_pf_pkg::ADDR_MODE0, 32'h90);
		repeat (1000) @(posedge i_clk_sys);
		check("scan irq", 32'(irq_cnt - n), 32'h0);
		for (int c = 0; c < 4; c++) begin
			rd(adc_pf_pkg::ADDR_RESULT_BASE + 6'(4 * c));
			check("scan result", rd_data, {22'h0, c[3:0], 6'h15});
		end
		// threshold write restarts the sweep, channel 0 now matches
		n = irq_cnt;
		wr(adc_pf_pkg::ADDR_PF_THRESHOLD, 32'h05);
		repeat (1000) @(posedge i_clk_sys);
		check("scan repeat", {31'h0, irq_cnt - n >= 2}, 32'h1);
		$display("done: continuous scan");
		// continuous select, select rewrite, stop
		wr(adc_pf_pkg::ADDR_PF_MODE, 32'h0);
		wr(adc_pf_pkg::ADDR_MODE0, 32'h80);
		n = irq_cnt;
		repeat (600) @(posedge i_clk_sys);
		check("select irq", {31'h0, irq_cnt - n >= 4}, 32'h1);
		wr(adc_pf_pkg::ADDR_SELECT, 32'h2);
		rd(adc_pf_pkg::ADDR_FLAG);
		check("flag kept", rd_data, 32'h1);
		wr(adc_pf_pkg::ADDR_MODE0, 32'h0);
		repeat (3) @(posedge i_clk_sys);
		check("power", {31'h0, o_analog_power}, 32'h0);
		n = irq_cnt;
		repeat (300) @(posedge i_clk_sys);
		check("stopped irq", 32'(irq_cnt - n), 32'h0);
		$display("done: continuous select");
		// one-shot scan 0..2, direction 1: channel 0 decides, then the sweep stops
		wr(adc_pf_pkg::ADDR_PF_MODE, 32'hc0);
		wr(adc_pf_pkg::ADDR_PF_THRESHOLD, 32'h06);
		wr(adc_pf_pkg::ADDR_FLAG, 32'h1);
		n = irq_cnt;
		wr(adc_pf_pkg::ADDR_MODE0, 32'hb0);
		repeat (600) @(posedge i_clk_sys);
		check("one-shot scan irq", 32'(irq_cnt - n), 32'h1);
		rd(adc_pf_pkg::ADDR_MODE0);
		check("scan stopped", {31'h0, rd_data[6]}, 32'h0);
		$display("done: one-shot scan");
		// plain storage and an unmapped place
		wr(adc_pf_pkg::ADDR_MODE2, 32'h5a);
		rd(adc_pf_pkg::ADDR_MODE2);
		check("mode2", rd_data, 32'h5a);
		rd(6'h18);
		check("unmapped resp", {30'h0, rd_resp}, {30'h0, adc_pf_pkg::RESP_SLVERR});
		check("unmapped data", rd_data, 32'h0);
		$display("done: registers");
		final_report();
	end
	// watchdog
	initial begin
		repeat (20000) @(posedge i_clk_sys);
		num_errors++;
		final_report();
	end
endmodule : testbench
